// ===== core/csup_top.v
/*
 Clock source supervisor: strap capture, clock mode decode, clock-loss monitor,
 sticky backup selection, PLL unlock handling, interrupt status and Wishbone slave.
 Assumes the free PLL clock and crystal are sampled in the mclk domain (mclk far faster),
 and that rst covers hardware, bidirectional software and watchdog resets.
*/
// Implementation choices: the register offsets and the Wishbone interface to the registers.
// Contract
// - monitor enabled after every reset
// - writing one to bit 4 disables monitor
// - monitor only in direct and prescaler modes
// - each PLL free cycle increments loss counter
// - each crystal transition clears loss counter
// - sixteen cycles without transition means failure
// - failure selects backup clock, sets interrupt
// - stay on backup despite returning crystal
// - only reset restores external clock source
// - disabled monitor: external clock, PLL off
// - straps sampled at reset; other codes PLL
// - PLL resyncs smoothly every F-th transition
// - four-divided codes multiply by 4,3,8,5
// - 010 gives ten, 011 one, 001 half
// - PLL unlock interrupts, free-runs until reset
`timescale 1ns/100ps
`include "csup_defs.vh"
module csup_top
(
	input wire mclk,
	input wire rst,
	input wire crystal_input_pin,
	input wire pll_free_clk,
	input wire pll_lock,
	input wire [2:0] clock_mode_strap_pins,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg irq_o,
	output reg [1:0] cpu_clk_src_o,
	output reg pll_power_o,
	output reg pll_ref_connect_o,
	output reg [2:0] pll_in_div_o,
	output reg [6:0] pll_mul_o,
	output reg [2:0] pll_out_div_o,
	output reg [4:0] pll_sync_f_o
);
	wire xtal_s;
	wire pllc_s;
	wire lock_s;
	wire [2:0] strap_s;
	reg xtal_q;
	reg pllc_q;
	reg lock_q;
	reg strap_done_q;
	reg [1:0] strap_wait_q;
	reg [2:0] mode_q;
	reg clock_monitor_disable_q;
	reg [`CSUP_CNT_W-1:0] cnt_q;
	reg [`CSUP_CNT_W-1:0] cnt_d;
	reg backup_q;
	reg unlocked_q;
	reg [1:0] status_q;
	reg [1:0] status_d;
	reg [1:0] mask_q;
	reg [1:0] src_d;
	reg [31:0] rdata_d;
	reg loss_evt;
	reg unlock_evt;
	reg monitor_mode;
	reg pll_mode;
	wire monitor_on;
	wire wb_req;
	wire wb_wr;
	wire wr_syscfg;
	wire wr_status;
	wire wr_mask;

	csup_sync2 u_sync_xtal (.mclk(mclk), .rst(rst), .d(crystal_input_pin), .q(xtal_s));
	csup_sync2 u_sync_pllc (.mclk(mclk), .rst(rst), .d(pll_free_clk), .q(pllc_s));
	csup_sync2 u_sync_lock (.mclk(mclk), .rst(rst), .d(pll_lock), .q(lock_s));
	csup_sync2 u_sync_s0 (.mclk(mclk), .rst(rst), .d(clock_mode_strap_pins[0]), .q(strap_s[0]));
	csup_sync2 u_sync_s1 (.mclk(mclk), .rst(rst), .d(clock_mode_strap_pins[1]), .q(strap_s[1]));
	csup_sync2 u_sync_s2 (.mclk(mclk), .rst(rst), .d(clock_mode_strap_pins[2]), .q(strap_s[2]));

	// straps caught once, on the third edge after release; pins may be reused later
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			strap_wait_q <= 2'h0;
			strap_done_q <= 1'b0;
			mode_q <= `CSUP_MODE_X4;
		end
		else if (!strap_done_q)
		begin
			// synchronisers restart with rst; wait until the pins have crossed
			if (strap_wait_q == `CSUP_STRAP_WAIT)
			begin
				strap_done_q <= 1'b1;
				mode_q <= strap_s;
			end
			else
				strap_wait_q <= strap_wait_q + 2'h1;
		end
	end

	always @*
	begin
		monitor_mode = (mode_q == `CSUP_MODE_DIRECT) || (mode_q == `CSUP_MODE_PRESC);
		// mode_q holds a PLL code until capture, so nothing may act on it yet
		pll_mode = strap_done_q && !monitor_mode;
	end

	assign monitor_on = strap_done_q && monitor_mode && !clock_monitor_disable_q;

	// loss counter; rising edge of the synced PLL clock counts, any crystal edge clears
	always @*
	begin
		cnt_d = cnt_q;
		loss_evt = 1'b0;
		if (!monitor_on || backup_q)
			cnt_d = {`CSUP_CNT_W{1'b0}};
		else if (xtal_s != xtal_q)
			cnt_d = {`CSUP_CNT_W{1'b0}};
		else if (pllc_s && !pllc_q)
		begin
			cnt_d = cnt_q + 1'b1;
			if (cnt_d == `CSUP_LOSS_CYCLES)
				loss_evt = 1'b1;
		end
	end

	always @*
	begin
		unlock_evt = pll_mode && strap_done_q && lock_q && !lock_s && !unlocked_q;
	end

	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			xtal_q <= 1'b0;
			pllc_q <= 1'b0;
			lock_q <= 1'b0;
			cnt_q <= {`CSUP_CNT_W{1'b0}};
			backup_q <= 1'b0;
			unlocked_q <= 1'b0;
		end
		else
		begin
			xtal_q <= xtal_s;
			pllc_q <= pllc_s;
			lock_q <= lock_s;
			cnt_q <= cnt_d;
			// only rst clears these latches
			if (loss_evt)
				backup_q <= 1'b1;
			if (unlock_evt)
				unlocked_q <= 1'b1;
		end
	end

	always @*
	begin
		if (backup_q)
			src_d = `CSUP_SRC_BACKUP;
		else if (!strap_done_q)
			src_d = `CSUP_SRC_XTAL;
		else if (mode_q == `CSUP_MODE_PRESC)
			src_d = `CSUP_SRC_PRESC;
		else if (mode_q == `CSUP_MODE_DIRECT)
			src_d = `CSUP_SRC_XTAL;
		else
			src_d = `CSUP_SRC_PLL;
	end

	// PLL divider settings per strap code; F doubles as resync interval
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pll_in_div_o <= 3'h4;
			pll_mul_o <= 7'h40;
			pll_out_div_o <= 3'h4;
			pll_sync_f_o <= 5'h04;
		end
		else
		begin
			case (mode_q)
				`CSUP_MODE_X4:
				begin
					pll_in_div_o <= 3'h4;
					pll_mul_o <= 7'h40;
					pll_out_div_o <= 3'h4;
					pll_sync_f_o <= 5'h04;
				end
				`CSUP_MODE_X3:
				begin
					pll_in_div_o <= 3'h4;
					pll_mul_o <= 7'h30;
					pll_out_div_o <= 3'h4;
					pll_sync_f_o <= 5'h03;
				end
				`CSUP_MODE_X8:
				begin
					pll_in_div_o <= 3'h4;
					pll_mul_o <= 7'h40;
					pll_out_div_o <= 3'h2;
					pll_sync_f_o <= 5'h08;
				end
				`CSUP_MODE_X5:
				begin
					pll_in_div_o <= 3'h4;
					pll_mul_o <= 7'h28;
					pll_out_div_o <= 3'h2;
					pll_sync_f_o <= 5'h05;
				end
				`CSUP_MODE_X10:
				begin
					pll_in_div_o <= 3'h2;
					pll_mul_o <= 7'h28;
					pll_out_div_o <= 3'h2;
					pll_sync_f_o <= 5'h0A;
				end
				`CSUP_MODE_X16:
				begin
					// no internal settings known; x16 via 4/64/1 keeps the factor
					pll_in_div_o <= 3'h4;
					pll_mul_o <= 7'h40;
					pll_out_div_o <= 3'h1;
					pll_sync_f_o <= 5'h10;
				end
				default:
				begin
					// bypass codes: settings unused
					pll_in_div_o <= 3'h1;
					pll_mul_o <= 7'h01;
					pll_out_div_o <= 3'h1;
					pll_sync_f_o <= 5'h01;
				end
			endcase
		end
	end

	// clock routing outputs
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cpu_clk_src_o <= `CSUP_SRC_XTAL;
			pll_power_o <= 1'b0;
			pll_ref_connect_o <= 1'b0;
		end
		else
		begin
			cpu_clk_src_o <= src_d;
			pll_power_o <= pll_mode || monitor_on || backup_q;
			// free-running PLL has no reference; unlock also cuts it until reset
			pll_ref_connect_o <= pll_mode && strap_done_q && !unlocked_q && !unlock_evt;
		end
	end

	// Wishbone classic slave, one wait-free ack per request
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;
	assign wr_syscfg = wb_wr && (wb_adr_i == `CSUP_ADDR_SYSCFG) && wb_sel_i[0];
	assign wr_status = wb_wr && (wb_adr_i == `CSUP_ADDR_STATUS) && wb_sel_i[0];
	assign wr_mask = wb_wr && (wb_adr_i == `CSUP_ADDR_MASK) && wb_sel_i[0];

	always @*
	begin
		status_d = status_q;
		if (wr_status)
			status_d = status_q & ~wb_dat_i[1:0];
		// set wins over a same-cycle clear
		if (loss_evt)
			status_d[`CSUP_ST_LOSS_BIT] = 1'b1;
		if (unlock_evt)
			status_d[`CSUP_ST_UNLOCK_BIT] = 1'b1;
	end

	always @*
	begin
		rdata_d = 32'h00000000;
		case (wb_adr_i)
			`CSUP_ADDR_SYSCFG: rdata_d[`CSUP_SYSCFG_DIS_BIT] = clock_monitor_disable_q;
			`CSUP_ADDR_STATUS: rdata_d[1:0] = status_q;
			`CSUP_ADDR_MASK: rdata_d[1:0] = mask_q;
			`CSUP_ADDR_MODE: rdata_d[7:0] = {unlocked_q, backup_q, src_d, 1'b0, mode_q};
			default: rdata_d = 32'h00000000;
		endcase
	end

	// bus response flops
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req && !wb_we_i) ? rdata_d : 32'h00000000;
		end
	end

	// configuration flops
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			clock_monitor_disable_q <= 1'b0;
			mask_q <= `CSUP_MASK_RESET;
		end
		else
		begin
			// write one disables; no way back short of reset
			if (wr_syscfg && wb_dat_i[`CSUP_SYSCFG_DIS_BIT])
				clock_monitor_disable_q <= 1'b1;
			if (wr_mask)
				mask_q <= wb_dat_i[1:0];
		end
	end

	// interrupt flops; irq follows the status being stored
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			status_q <= 2'h0;
			irq_o <= 1'b0;
		end
		else
		begin
			status_q <= status_d;
			irq_o <= |(status_d & mask_q);
		end
	end
endmodule

// ===== core/csup_defs.vh
/*
 Shared constants of the clock source supervisor: register offsets, field positions,
 reset values, strap codes and counter figures.
 Assumes inclusion by bare name from core/ design files.
*/
`ifndef CSUP_DEFS_VH
`define CSUP_DEFS_VH

`define CSUP_ADDR_SYSCFG 8'h00
`define CSUP_ADDR_STATUS 8'h04
`define CSUP_ADDR_MASK 8'h08
`define CSUP_ADDR_MODE 8'h0C

`define CSUP_SYSCFG_DIS_BIT 4
`define CSUP_SYSCFG_RESET 32'h00000000

`define CSUP_ST_LOSS_BIT 0
`define CSUP_ST_UNLOCK_BIT 1
`define CSUP_MASK_RESET 2'h0

`define CSUP_MODE_X4 3'h7
`define CSUP_MODE_X3 3'h6
`define CSUP_MODE_X8 3'h5
`define CSUP_MODE_X5 3'h4
`define CSUP_MODE_DIRECT 3'h3
`define CSUP_MODE_X10 3'h2
`define CSUP_MODE_PRESC 3'h1
`define CSUP_MODE_X16 3'h0

`define CSUP_LOSS_CYCLES 5'h10
`define CSUP_CNT_W 5
`define CSUP_STRAP_WAIT 2'h2

`define CSUP_SRC_XTAL 2'h0
`define CSUP_SRC_PRESC 2'h1
`define CSUP_SRC_PLL 2'h2
`define CSUP_SRC_BACKUP 2'h3

`endif

// ===== core/csup_sync2.v
/*
 Two-flop synchroniser for one level bit.
 Assumes d comes from outside the mclk domain.
*/
`timescale 1ns/100ps
module csup_sync2
(
	input wire mclk,
	input wire rst,
	input wire d,
	output wire q
);
	reg meta_q;
	reg sync_q;
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end
	assign q = sync_q;
endmodule

// ===== tb/csup_osc.sv
/* Far-side model: crystal and free PLL clock.
 Assumes run starts and stops the crystal, slow picks 4 instead of 8 MHz. */
`timescale 1ns/100ps
module csup_osc
(
	input logic run,
	input logic slow,
	input logic pwr,
	output logic xtal,
	output logic pclk
);
	initial xtal = 0;
	initial pclk = 0;
	// a dead crystal holds its level
	// crystal rate chosen per strap so PLL input, VCO and CPU clock stay legal
	always
	begin
		#(slow ? 125 : 62.5);
		if (run)
			xtal = ~xtal;
	end
	always #20 pclk = pwr ? ~pclk : 1'b0;
endmodule

// ===== tb/csup_assertions.sv
/* Port checker of the supervisor.
 Assumes straps held steady out of reset. */
`timescale 1ns/100ps
module csup_chk
(
	input logic mclk,
	input logic rst,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_ack_o,
	input logic [31:0] wb_dat_o,
	input logic [2:0] clock_mode_strap_pins,
	input logic [1:0] cpu_clk_src_o,
	input logic pll_power_o,
	input logic pll_ref_connect_o
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic mon;
	assign mon = clock_mode_strap_pins inside {3'h3, 3'h1};
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack; s_req |=> s_ack; endproperty
	property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	property p_stk; cpu_clk_src_o == 2'h3 |=> cpu_clk_src_o == 2'h3; endproperty
	property p_ref; $fell(pll_ref_connect_o) |-> !pll_ref_connect_o [*8]; endproperty
	property p_off; !pll_power_o |-> cpu_clk_src_o < 2'h2; endproperty
	property p_bk; cpu_clk_src_o == 2'h3 |-> mon && pll_power_o; endproperty
	property p_pll; cpu_clk_src_o == 2'h2 |-> !mon; endproperty
	property p_mon; mon |-> cpu_clk_src_o != 2'h2; endproperty
	a_ack: assert property (p_ack) else $error("bad ack");
	a_dat: assert property (p_dat) else $error("data without ack");
	a_stk: assert property (p_stk) else $error("left backup");
	a_ref: assert property (p_ref) else $error("ref back");
	a_off: assert property (p_off) else $error("pll off src");
	a_bk: assert property (p_bk) else $error("bad backup");
	a_pll: assert property (p_pll) else $error("bad pll src");
	a_mon: assert property (p_mon) else $error("pll in direct");
endmodule
bind csup_top csup_chk u_chk (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
	.clock_mode_strap_pins, .cpu_clk_src_o, .pll_power_o, .pll_ref_connect_o);

// ===== tb/clock_source_supervisor_test.sv
/* Self-checking bench of the supervisor.
 Assumes the design answers reads with ack. */
`timescale 1ns/100ps
module clock_source_supervisor_test;
	logic mclk = 0, rst = 1, run = 1, pll_lock = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic crystal_input_pin, pll_free_clk, wb_ack_o, irq_o, pll_power_o, pll_ref_connect_o;
	logic slow = 0;
	logic [2:0] clock_mode_strap_pins = 3'h3, pll_in_div_o, pll_out_div_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
	logic [3:0] wb_sel_i = 4'hF;
	logic [1:0] cpu_clk_src_o;
	logic [6:0] pll_mul_o;
	logic [4:0] pll_sync_f_o;
	logic [31:0] q[$];
	int fail_count = 0, check_count = 0, seed = 9;
	int cd[5] = '{7, 6, 5, 4, 2};
	int id[5] = '{4, 4, 4, 4, 2};
	int ml[5] = '{64, 48, 64, 40, 40};
	int od[5] = '{4, 4, 2, 2, 2};
	int ff[5] = '{4, 3, 8, 5, 10};
	int sl[5] = '{0, 0, 1, 0, 1};
	csup_top dut (.mclk, .rst, .crystal_input_pin, .pll_free_clk, .pll_lock,
		.clock_mode_strap_pins, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
		.wb_sel_i, .wb_dat_o, .wb_ack_o, .irq_o, .cpu_clk_src_o, .pll_power_o,
		.pll_ref_connect_o, .pll_in_div_o, .pll_mul_o, .pll_out_div_o, .pll_sync_f_o);
	csup_osc u_osc (.run, .slow, .pwr(pll_power_o), .xtal(crystal_input_pin),
		.pclk(pll_free_clk));
	initial forever #2 mclk = ~mclk;
	task chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		wb(0, a, 0);
	endtask
	task rs(input logic [2:0] s);
		rst <= 1;
		clock_mode_strap_pins <= s;
		repeat (6) @(posedge mclk);
		rst <= 0;
		repeat (5) @(posedge mclk);
	endtask
	always @(posedge mclk)
		if (wb_ack_o === 1'b1 && !wb_we_i && q.size() > 0)
			chk("rdata", wb_dat_o, q.pop_front());
	initial
	begin
		#200000;
		fail_count++;
		wrap_up;
	end
	initial
	begin
		rs(3'h3);
		rd(8'h0C, 32'h03);
		chk("pwr", pll_power_o, 1);
		r = $random(seed);
		wb(1, 8'h08, r);
		rd(8'h08, {30'h0, r[1:0]});
		rd(8'h20, 0);
		wb(1, 8'h08, 1);
		run <= 0;
		repeat (100) @(posedge mclk);
		chk("early", cpu_clk_src_o, 0);
		repeat (200) if (cpu_clk_src_o !== 2'h3) @(posedge mclk);
		chk("bk", cpu_clk_src_o, 3);
		chk("irq", irq_o, 1);
		rd(8'h04, 1);
		rd(8'h0C, 32'h73);
		wb(1, 8'h08, 0);
		chk("irq", irq_o, 0);
		wb(1, 8'h04, 1);
		rd(8'h04, 0);
		rd(8'h0C, 32'h73);
		run <= 1;
		repeat (50) @(posedge mclk);
		chk("stay", cpu_clk_src_o, 3);
		rs(3'h3);
		chk("back", cpu_clk_src_o, 0);
		wb(1, 8'h00, 32'h10);
		rd(8'h00, 32'h10);
		chk("pwr", pll_power_o, 0);
		run <= 0;
		repeat (250) @(posedge mclk);
		chk("src", cpu_clk_src_o, 0);
		run <= 1;
		rs(3'h1);
		chk("src", cpu_clk_src_o, 1);
		repeat (250) @(posedge mclk);
		chk("src", cpu_clk_src_o, 1);
		for (int i = 0; i < 5; i++)
		begin
			slow <= sl[i];
			rs(cd[i]);
			chk("src", cpu_clk_src_o, 2);
			chk("idiv", pll_in_div_o, id[i]);
			chk("mul", pll_mul_o, ml[i]);
			chk("odiv", pll_out_div_o, od[i]);
			chk("f", pll_sync_f_o, ff[i]);
		end
		chk("ref", pll_ref_connect_o, 1);
		run <= 0;
		repeat (250) @(posedge mclk);
		chk("src", cpu_clk_src_o, 2);
		run <= 1;
		wb(1, 8'h08, 2);
		pll_lock <= 0;
		repeat (6) @(posedge mclk);
		chk("ref", pll_ref_connect_o, 0);
		chk("irq", irq_o, 1);
		rd(8'h04, 2);
		pll_lock <= 1;
		repeat (6) @(posedge mclk);
		chk("ref", pll_ref_connect_o, 0);
		wrap_up;
	end
endmodule
